// ===== core/clock_meter.v
// counts edges of one client clock over a window of system clock cycles
`timescale 1ns/1ps
`default_nettype none
module clock_meter
#(
   parameter WINDOW = 1000000,
   parameter EXPECT = 312500
)
(
   input wire clock,
   input wire rst_n,
   input wire edge_pulse,
   output reg signed [19:0] diff,
   output reg done
);
   reg [19:0] win_reg;
   reg [19:0] cnt_reg;
   always @(posedge clock or negedge rst_n)
   begin
      if (!rst_n)
      begin
         win_reg <= 20'h0;
         cnt_reg <= 20'h0;
         diff <= 20'sh0;
         done <= 1'b0;
      end
      else
      begin
         done <= 1'b0;
         if (win_reg == WINDOW[19:0] - 20'h1)
         begin
            // window end: measured minus expected edges
            win_reg <= 20'h0;
            cnt_reg <= 20'h0;
            // the closing cycle's edge belongs to this window too
            diff <= $signed(cnt_reg + {19'h0, edge_pulse}) -
               $signed(EXPECT[19:0]);
            done <= 1'b1;
         end
         else
         begin
            win_reg <= win_reg + 20'h1;
            cnt_reg <= cnt_reg + {19'h0, edge_pulse};
         end
      end
   end
endmodule
`default_nettype wire

// ===== core/edge_sync.v
// three-flop synchroniser with agreement filter and rising edge pulse
`timescale 1ns/1ps
`default_nettype none
module edge_sync
(
   input wire clock,
   input wire rst_n,
   input wire din,
   output reg level,
   output reg rise
);
   reg s1_reg;
   reg s2_reg;
   reg s3_reg;
   always @(posedge clock or negedge rst_n)
   begin
      if (!rst_n)
      begin
         s1_reg <= 1'b0;
         s2_reg <= 1'b0;
         s3_reg <= 1'b0;
         level <= 1'b0;
         rise <= 1'b0;
      end
      else
      begin
         s1_reg <= din;
         s2_reg <= s1_reg;
         s3_reg <= s2_reg;
         // change counts once second and third agree
         if (s2_reg == s3_reg)
            level <= s3_reg;
         rise <= (s2_reg == s3_reg) && s3_reg && !level;
      end
   end
endmodule
`default_nettype wire

// ===== core/sync_port_ctrl.v
// sync serial port carrier-detect and clock-select with axi4-lite registers
`timescale 1ns/1ps
`default_nettype none
`include "sync_port_defines.vh"
module sync_port_ctrl
#(
   parameter WINDOW = 1000000,
   parameter EXPECT = 312500
)
(
   input wire clock,
   input wire rst_b,
   input wire s_axi_awvalid,
   output reg s_axi_awready,
   input wire [7:0] s_axi_awaddr,
   input wire s_axi_wvalid,
   output reg s_axi_wready,
   input wire [31:0] s_axi_wdata,
   input wire [3:0] s_axi_wstrb,
   output reg s_axi_bvalid,
   input wire s_axi_bready,
   output reg [1:0] s_axi_bresp,
   input wire s_axi_arvalid,
   output reg s_axi_arready,
   input wire [7:0] s_axi_araddr,
   output reg s_axi_rvalid,
   input wire s_axi_rready,
   output reg [31:0] s_axi_rdata,
   output reg [1:0] s_axi_rresp,
   input wire link_sync,
   input wire remote_dcd,
   input wire remote_rts,
   input wire client_rxc,
   input wire client_txc,
   input wire ext_txc,
   input wire term_clk,
   output reg dcd_out,
   output reg txc_sel_out,
   output reg rxc_sel_out,
   output reg [5:0] overhead_kbps,
   output reg clock_master_ext,
   output reg [19:0] clk_diff_rx,
   output reg [19:0] clk_diff_tx
);
   reg rs1_reg;
   reg rs2_reg;
   wire rst_n;
   // two-flop release so every flop leaves reset on the same edge
   always @(posedge clock or negedge rst_b)
   begin
      if (!rst_b)
      begin
         rs1_reg <= 1'b0;
         rs2_reg <= 1'b0;
      end
      else
      begin
         rs1_reg <= 1'b1;
         rs2_reg <= rs1_reg;
      end
   end
   assign rst_n = rs2_reg;

   wire sync_lvl, rdcd_lvl, rrts_lvl, rxc_lvl, xtxc_lvl, term_lvl;
   wire rxc_rise, txc_rise;
   edge_sync u_s0 (.clock(clock), .rst_n(rst_n), .din(link_sync),
      .level(sync_lvl), .rise());
   edge_sync u_s1 (.clock(clock), .rst_n(rst_n), .din(remote_dcd),
      .level(rdcd_lvl), .rise());
   edge_sync u_s2 (.clock(clock), .rst_n(rst_n), .din(remote_rts),
      .level(rrts_lvl), .rise());
   edge_sync u_s3 (.clock(clock), .rst_n(rst_n), .din(client_rxc),
      .level(rxc_lvl), .rise(rxc_rise));
   edge_sync u_s4 (.clock(clock), .rst_n(rst_n), .din(client_txc),
      .level(), .rise(txc_rise));
   edge_sync u_s5 (.clock(clock), .rst_n(rst_n), .din(ext_txc),
      .level(xtxc_lvl), .rise());
   edge_sync u_s6 (.clock(clock), .rst_n(rst_n), .din(term_clk),
      .level(term_lvl), .rise());

   wire signed [19:0] rx_diff;
   wire signed [19:0] tx_diff;
   wire rx_done;
   wire tx_done;
   // measurement runs always; clk_diff_rx published in overhead modes 2, 3, 5 and 7, clk_diff_tx in mode 2 only
   clock_meter #(.WINDOW(WINDOW), .EXPECT(EXPECT)) u_mrx (.clock(clock),
      .rst_n(rst_n), .edge_pulse(rxc_rise), .diff(rx_diff),
      .done(rx_done));
   clock_meter #(.WINDOW(WINDOW), .EXPECT(EXPECT)) u_mtx (.clock(clock),
      .rst_n(rst_n), .edge_pulse(txc_rise), .diff(tx_diff),
      .done(tx_done));

   reg [31:0] ctrl_reg;
   reg [2:0] clk_mode_reg;
   reg reject_reg;
   reg master_ok_reg;

   function mode_ok;
      input [2:0] m;
      input cloud;
      begin
         if (cloud)
            mode_ok = (m == 3'd0) || (m == 3'd4) || (m == 3'd5);
         else
            mode_ok = (m == 3'd2) || (m == 3'd3) || (m == 3'd6) ||
               (m == 3'd7);
      end
   endfunction

   function [5:0] overhead;
      input [2:0] m;
      begin
         case (m)
            3'd2: overhead = `OVH_TWO;
            3'd3, 3'd5, 3'd7: overhead = `OVH_ONE;
            default: overhead = `OVH_NONE;
         endcase
      end
   endfunction

   // axi4-lite write: address and data may arrive in either order
   reg aw_held_reg;
   reg w_held_reg;
   reg [7:0] aw_addr_reg;
   reg [31:0] w_data_reg;
   reg [3:0] w_strb_reg;
   wire do_write = aw_held_reg && w_held_reg && !s_axi_bvalid;
   wire [31:0] wmask = {{8{w_strb_reg[3]}}, {8{w_strb_reg[2]}},
      {8{w_strb_reg[1]}}, {8{w_strb_reg[0]}}};
   wire [2:0] new_mode = w_data_reg[2:0] & wmask[2:0];
   always @(posedge clock or negedge rst_n)
   begin
      if (!rst_n)
      begin
         s_axi_awready <= 1'b0;
         s_axi_wready <= 1'b0;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= 2'b00;
         aw_held_reg <= 1'b0;
         w_held_reg <= 1'b0;
         aw_addr_reg <= 8'h0;
         w_data_reg <= 32'h0;
         w_strb_reg <= 4'h0;
         ctrl_reg <= `CTRL_RESET;
         clk_mode_reg <= `CLK_MODE_RESET;
         reject_reg <= 1'b0;
      end
      else
      begin
         s_axi_awready <= !aw_held_reg && !s_axi_awready && s_axi_awvalid;
         s_axi_wready <= !w_held_reg && !s_axi_wready && s_axi_wvalid;
         if (s_axi_awvalid && s_axi_awready)
         begin
            aw_held_reg <= 1'b1;
            aw_addr_reg <= s_axi_awaddr;
         end
         if (s_axi_wvalid && s_axi_wready)
         begin
            w_held_reg <= 1'b1;
            w_data_reg <= s_axi_wdata;
            w_strb_reg <= s_axi_wstrb;
         end
         if (do_write)
         begin
            aw_held_reg <= 1'b0;
            w_held_reg <= 1'b0;
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= 2'b00;
            if (aw_addr_reg == `ADDR_CTRL)
               ctrl_reg <= (ctrl_reg & ~wmask) | (w_data_reg & wmask);
            else if (aw_addr_reg == `ADDR_CLKSEL)
            begin
               // a mode illegal for the topology keeps the old one
               if (mode_ok(new_mode, ctrl_reg[`CTRL_TOPO_CLOUD]))
               begin
                  clk_mode_reg <= new_mode;
                  reject_reg <= 1'b0;
               end
               else
               begin
                  reject_reg <= 1'b1;
                  // slverr tells software the mode was refused
                  s_axi_bresp <= 2'b10;
               end
            end
            else if (aw_addr_reg != `ADDR_STATUS &&
               aw_addr_reg != `ADDR_MEAS)
               s_axi_bresp <= 2'b10;
         end
         else if (s_axi_bvalid && s_axi_bready)
            s_axi_bvalid <= 1'b0;
      end
   end

   // rx clock ppm check against EXPECT edges, window of system clock cycles
   wire pass_mode = (overhead(clk_mode_reg) != `OVH_NONE);
   wire master_mode = (clk_mode_reg == 3'd6) && ctrl_reg[`CTRL_EXT_MASTER];
   wire [19:0] abs_rx = rx_diff[19] ? (20'h0 - rx_diff) : rx_diff;
   // |diff| * 1e6 / expect against the limit, cross-multiplied
   // so no divider is needed
   wire [39:0] ppm_lhs = {20'h0, abs_rx} * `PPM_SCALE;
   wire [39:0] ppm_rhs = {20'h0, EXPECT[19:0]} * {20'h0, `PPM_LIMIT};
   always @(posedge clock or negedge rst_n)
   begin
      if (!rst_n)
      begin
         master_ok_reg <= 1'b0;
         s_axi_arready <= 1'b0;
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= 32'h0;
         s_axi_rresp <= 2'b00;
      end
      else
      begin
         // limitation: ppm judged coarsely as edges per window
         if (rx_done)
            master_ok_reg <= (ppm_lhs <= ppm_rhs);
         s_axi_arready <= !s_axi_arready && !s_axi_rvalid && s_axi_arvalid;
         if (s_axi_arvalid && s_axi_arready)
         begin
            s_axi_rvalid <= 1'b1;
            s_axi_rresp <= 2'b00;
            case (s_axi_araddr)
               `ADDR_CTRL: s_axi_rdata <= ctrl_reg & 32'h000000ff;
               `ADDR_CLKSEL: s_axi_rdata <= {29'h0, clk_mode_reg};
               `ADDR_STATUS: s_axi_rdata <= {24'h0, master_ok_reg,
                  reject_reg, overhead_kbps};
               `ADDR_MEAS: s_axi_rdata <= {rx_diff[15:0], tx_diff[15:0]};
               default:
               begin
                  s_axi_rdata <= 32'h0;
                  s_axi_rresp <= 2'b10;
               end
            endcase
         end
         else if (s_axi_rvalid && s_axi_rready)
            s_axi_rvalid <= 1'b0;
      end
   end

   // carrier detect, tx/rx clock source and overhead
   wire sig_en = ctrl_reg[`CTRL_REMOTE_SIG];
   reg dcd_next;
   always @*
   begin
      case (ctrl_reg[1:0])
         `DCD_OFF: dcd_next = 1'b0;
         `DCD_ON: dcd_next = 1'b1;
         `DCD_REM_DCD:
            if (ctrl_reg[`CTRL_REMOTE_DCE])
               dcd_next = sync_lvl;
            else
               dcd_next = sync_lvl && sig_en && rdcd_lvl;
         `DCD_REM_RTS: dcd_next = sync_lvl && sig_en && rrts_lvl;
         default: dcd_next = 1'b0;
      endcase
      // dte port: mode ignored, line held off
      if (!ctrl_reg[`CTRL_PORT_DCE])
         dcd_next = 1'b0;
   end

   always @(posedge clock or negedge rst_n)
   begin
      if (!rst_n)
      begin
         dcd_out <= 1'b0;
         txc_sel_out <= 1'b0;
         rxc_sel_out <= 1'b0;
         overhead_kbps <= `OVH_NONE;
         clock_master_ext <= 1'b0;
         clk_diff_rx <= 20'h0;
         clk_diff_tx <= 20'h0;
      end
      else
      begin
         dcd_out <= dcd_next;
         overhead_kbps <= overhead(clk_mode_reg);
         // modes 0 and 4: clocks only, no x.21 protocol engine
         if (clk_mode_reg == 3'd0 || clk_mode_reg == 3'd4)
         begin
            txc_sel_out <= term_lvl;
            rxc_sel_out <= term_lvl;
         end
         else if (clk_mode_reg == 3'd6)
         begin
            txc_sel_out <= rxc_lvl;
            rxc_sel_out <= rxc_lvl;
         end
         else
         begin
            txc_sel_out <= ctrl_reg[`CTRL_XTXC_EN] ? xtxc_lvl :
               term_lvl;
            rxc_sel_out <= rxc_lvl;
         end
         clock_master_ext <= master_mode && master_ok_reg;
         if (pass_mode && rx_done)
            clk_diff_rx <= rx_diff;
         if (clk_mode_reg == 3'd2 && tx_done)
            clk_diff_tx <= tx_diff;
      end
   end
endmodule
`default_nettype wire

// ===== core/sync_port_defines.vh
// constants for the sync serial port carrier-detect and clock-select block
`ifndef SYNC_PORT_DEFINES_VH
`define SYNC_PORT_DEFINES_VH
`define ADDR_CTRL 8'h00
`define ADDR_CLKSEL 8'h04
`define ADDR_STATUS 8'h08
`define ADDR_MEAS 8'h0c
`define CTRL_RESET 32'h00000000
`define CTRL_DCD_MODE_LSB 0
`define CTRL_PORT_DCE 2
`define CTRL_REMOTE_DCE 3
`define CTRL_REMOTE_SIG 4
`define CTRL_XTXC_EN 5
`define CTRL_TOPO_CLOUD 6
`define CTRL_EXT_MASTER 7
`define DCD_OFF 2'd0
`define DCD_ON 2'd1
`define DCD_REM_DCD 2'd2
`define DCD_REM_RTS 2'd3
`define CLK_MODE_RESET 3'd0
`define OVH_NONE 6'd0
`define OVH_ONE 6'd40
`define OVH_TWO 6'd56
`define WINDOW_CYCLES 20'd1000000
`define PPM_LIMIT 20'd100
`define PPM_SCALE 40'd1000000
`endif

// ===== tb/client_model.sv
// client equipment whose clocks are slaved to the terminal clock
`timescale 1ns/1ps
`default_nettype none
module client_model
(
   input wire logic term_clk,
   input wire logic run,
   output logic client_rxc,
   output logic client_txc,
   output logic ext_txc
);
   initial {client_rxc, client_txc, ext_txc} = 3'b000;
   // no free-running source of its own; clocks stand still until run
   always @(term_clk)
   begin
      if (run)
      begin
         client_rxc <= #4 term_clk;
         client_txc <= #5 term_clk;
         ext_txc <= #7 !term_clk;
      end
   end
endmodule
`default_nettype wire

// ===== tb/sync_port_ctrl_asserts.sv
// assertion checker for the carrier-detect and clock-select block
`timescale 1ns/1ps
`default_nettype none
module sync_port_ctrl_asserts
(
   input wire clock,
   input wire rst_b,
   input wire [7:0] s_axi_awaddr,
   input wire [31:0] s_axi_wdata,
   input wire s_axi_bvalid,
   input wire s_axi_bready,
   input wire s_axi_rvalid,
   input wire s_axi_rready,
   input wire link_sync,
   input wire remote_dcd,
   input wire remote_rts,
   input wire dcd_out,
   input wire [5:0] overhead_kbps
);
   logic [7:0] ctrl_reg;
   logic [3:0] quiet_reg;
   wire st = quiet_reg >= 4'h8;
   wire pd = ctrl_reg[2];
   wire [1:0] m = ctrl_reg[1:0];
   // shadow control word; the master holds address and data after release
   always @(posedge clock or negedge rst_b)
   begin
      if (!rst_b)
      begin
         ctrl_reg <= 8'h00;
         quiet_reg <= 4'h0;
      end
      else
      begin
         if (s_axi_bvalid && s_axi_bready && s_axi_awaddr == 8'h00)
            ctrl_reg <= s_axi_wdata[7:0];
         // dcd lags its inputs by the synchroniser, so wait for quiet
         if (s_axi_bvalid || $changed({link_sync, remote_dcd, remote_rts}))
            quiet_reg <= 4'h0;
         else if (quiet_reg != 4'hf)
            quiet_reg <= quiet_reg + 4'h1;
      end
   end
   default clocking @(posedge clock); endclocking
   default disable iff (!rst_b);
   property p_dte_off; st && !pd |-> !dcd_out; endproperty
   a_dte_off: assert property (p_dte_off)
      else $error("dcd on with dte port");
   property p_off; st && pd && m == 2'd0 |-> !dcd_out; endproperty
   a_off: assert property (p_off)
      else $error("dcd on in off mode");
   property p_on; st && pd && m == 2'd1 |-> dcd_out; endproperty
   a_on: assert property (p_on)
      else $error("dcd off in on mode");
   property p_rem_dcd;
      st && pd && m == 2'd2 && ctrl_reg[4]
         |-> dcd_out == (link_sync && (ctrl_reg[3] || remote_dcd));
   endproperty
   a_rem_dcd: assert property (p_rem_dcd)
      else $error("dcd wrong in remote dcd mode");
   property p_rem_rts;
      st && pd && m == 2'd3 && ctrl_reg[4] && ctrl_reg[3]
         |-> dcd_out == (link_sync && remote_rts);
   endproperty
   a_rem_rts: assert property (p_rem_rts)
      else $error("dcd wrong in remote rts mode");
   property p_ovh; overhead_kbps inside {6'd0, 6'd40, 6'd56}; endproperty
   a_ovh: assert property (p_ovh)
      else $error("illegal overhead value");
   property p_bonce; s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid; endproperty
   a_bonce: assert property (p_bonce)
      else $error("second write response");
   property p_ronce; s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid; endproperty
   a_ronce: assert property (p_ronce)
      else $error("second read response");
endmodule
`default_nettype wire

// ===== tb/tb_sync_port_ctrl.sv
// testbench for the carrier-detect and clock-select block
`timescale 1ns/1ps
`default_nettype none
module tb_sync_port_ctrl;
   logic clock = 1'b0, rst_b = 1'b0, term_clk = 1'b0, run = 1'b0;
   logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
   logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
   logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
   logic [31:0] s_axi_wdata = 32'h0;
   logic link_sync = 1'b0, remote_dcd = 1'b0, remote_rts = 1'b0;
   wire client_rxc, client_txc, ext_txc, dcd_out;
   wire s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
   wire [1:0] s_axi_bresp, s_axi_rresp;
   wire [31:0] s_axi_rdata;
   wire [5:0] overhead_kbps;
   wire txc_sel_out, rxc_sel_out, clock_master_ext;
   wire [19:0] clk_diff_rx, clk_diff_tx;
   logic [14:0] hist = 15'h0;
   logic [1:0] sel_src = 2'd0;
   int n_fail = 0, checks = 0;
   integer seed = 32'h751e;
   logic [1:0] wq[$];
   logic [65:0] rq[$], e;
   always #10 clock = ~clock;
   initial
   begin
      #7;
      forever #80 term_clk = ~term_clk;
   end
   client_model partner (.term_clk, .run, .client_rxc, .client_txc, .ext_txc);
   sync_port_ctrl #(.WINDOW(1000), .EXPECT(125)) DUT (.clock, .rst_b,
      .s_axi_awvalid, .s_axi_awready, .s_axi_awaddr, .s_axi_wvalid,
      .s_axi_wready, .s_axi_wdata, .s_axi_wstrb(4'hf), .s_axi_bvalid,
      .s_axi_bready, .s_axi_bresp, .s_axi_arvalid, .s_axi_arready,
      .s_axi_araddr, .s_axi_rvalid, .s_axi_rready, .s_axi_rdata,
      .s_axi_rresp, .link_sync, .remote_dcd, .remote_rts, .client_rxc,
      .client_txc, .ext_txc, .term_clk, .dcd_out, .txc_sel_out,
      .rxc_sel_out, .overhead_kbps, .clock_master_ext, .clk_diff_rx,
      .clk_diff_tx);
   task automatic chk(input logic [31:0] seen, exp, input string what);
      checks++;
      if (seen !== exp)
      begin
         n_fail++;
         $display("mismatch %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task final_report;
      if (n_fail == 0 && checks > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d,
      input logic [1:0] r);
      int n;
      @(posedge clock);
      wq.push_back(r);
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      for (n = 0; n < 40; n++)
      begin
         @(posedge clock);
         if (s_axi_awready) s_axi_awvalid <= 1'b0;
         if (s_axi_wready) s_axi_wvalid <= 1'b0;
         if (s_axi_bvalid) break;
      end
      s_axi_bready <= 1'b0;
      if (n == 40)
      begin
         n_fail++;
         final_report;
      end
   endtask
   task automatic rd(input logic [7:0] a, input logic [31:0] k, d,
      input logic [1:0] r);
      int n;
      @(posedge clock);
      rq.push_back({r, k, d});
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      for (n = 0; n < 40; n++)
      begin
         @(posedge clock);
         if (s_axi_arready) s_axi_arvalid <= 1'b0;
         if (s_axi_rvalid) break;
      end
      s_axi_rready <= 1'b0;
      if (n == 40)
      begin
         n_fail++;
         final_report;
      end
   endtask
   // responses are matched against the oldest note as they appear
   always @(posedge clock)
   begin
      // pin samples five edges back: three sync flops, filter, output
      hist <= {hist[11:0], term_clk, ext_txc, client_rxc};
      if (sel_src != 2'd0)
      begin
         chk(rxc_sel_out, hist[12], "rxc_sel");
         chk(txc_sel_out, hist[11 + sel_src], "txc_sel");
      end
      if (s_axi_bvalid && s_axi_bready && wq.size() > 0)
         chk(s_axi_bresp, wq.pop_front(), "bresp");
      if (s_axi_rvalid && s_axi_rready && rq.size() > 0)
      begin
         e = rq.pop_front();
         chk(s_axi_rresp, e[65:64], "rresp");
         chk(s_axi_rdata & e[63:32], e[31:0], "rdata");
      end
   end
   function automatic logic [5:0] ovh(input logic cl, input logic [2:0] m);
      if (cl) return (m == 3'd5) ? 6'd40 : 6'd0;
      case (m)
         3'd2: return 6'd56;
         3'd3, 3'd7: return 6'd40;
         default: return 6'd0;
      endcase
   endfunction
   initial
   begin
      int c, m, k;
      logic ok;
      logic [2:0] cur;
      logic [31:0] r;
      repeat (4) @(posedge clock);
      rst_b <= 1'b1;
      repeat (3) @(posedge clock);
      run <= 1'b1;
      rd(8'h00, 32'hffffffff, 32'h0, 2'b00);
      rd(8'h04, 32'h7, 32'h0, 2'b00);
      rd(8'h10, 32'hffffffff, 32'h0, 2'b10);
      wr(8'h10, 32'h1, 2'b10);
      cur = 3'd0;
      for (c = 0; c < 2; c++)
      begin
         wr(8'h00, {25'h0, c[0], 6'h0}, 2'b00);
         for (m = 0; m < 8; m++)
         begin
            ok = (c[0] ? 8'h31 : 8'hcc) >> m;
            wr(8'h04, m, ok ? 2'b00 : 2'b10);
            if (ok) cur = m[2:0];
            rd(8'h04, 32'h7, {29'h0, cur}, 2'b00);
            rd(8'h08, 32'h7f, {25'h0, !ok, ovh(c[0], cur)},
               2'b00);
         end
      end
      // every dcd mode and remote role, with random line states
      for (k = 0; k < 32; k++)
      begin
         r = $random(seed);
         wr(8'h00, {27'h0, k[4:0]}, 2'b00);
         @(posedge clock);
         {link_sync, remote_dcd, remote_rts} <= r[2:0];
         repeat (10) @(posedge clock);
         if (!k[2]) chk(dcd_out, 0, "dcd");
         else if (k[1:0] == 0) chk(dcd_out, 0, "dcd");
         else if (k[1:0] == 1) chk(dcd_out, 1, "dcd");
         else if (k[1:0] == 2)
            chk(dcd_out, r[2] & (k[3] | k[4] & r[1]),
               "dcd");
         else if (k[3])
            chk(dcd_out, r[2] & k[4] & r[0], "dcd");
      end
      // pipe, dce port, master request: mode 6 locks tx to rx clock
      wr(8'h00, 32'h84, 2'b00);
      wr(8'h04, 32'h6, 2'b00);
      repeat (2) @(posedge clock);
      sel_src <= 2'd1;
      repeat (2100) @(posedge clock);
      chk(clock_master_ext, 1, "master");
      chk(overhead_kbps, 0, "ovh");
      sel_src <= 2'd0;
      wr(8'h00, 32'ha4, 2'b00);
      wr(8'h04, 32'h7, 2'b00);
      repeat (2) @(posedge clock);
      sel_src <= 2'd2;
      repeat (2100) @(posedge clock);
      chk(clk_diff_rx, 0, "diff_rx");
      chk(clock_master_ext, 0, "master");
      sel_src <= 2'd0;
      wr(8'h00, 32'h84, 2'b00);
      repeat (2) @(posedge clock);
      sel_src <= 2'd3;
      repeat (20) @(posedge clock);
      sel_src <= 2'd0;
      // client clocks stopped: a whole window of missing edges
      wr(8'h04, 32'h2, 2'b00);
      run <= 1'b0;
      repeat (2100) @(posedge clock);
      chk(clk_diff_rx, 32'hfff83, "diff_rx");
      chk(clk_diff_tx, 32'hfff83, "diff_tx");
      @(posedge clock);
      if (wq.size() != 0 || rq.size() != 0) n_fail++;
      final_report;
   end
endmodule
bind sync_port_ctrl sync_port_ctrl_asserts checker_inst (.clock, .rst_b,
   .s_axi_awaddr, .s_axi_wdata, .s_axi_bvalid, .s_axi_bready,
   .s_axi_rvalid, .s_axi_rready, .link_sync, .remote_dcd, .remote_rts,
   .dcd_out, .overhead_kbps);
`default_nettype wire
